// [common/ogt_pkg.sv]
// Constants for the per-core offset and fine gain trim bank.
// Assumes an APB master on 32-bit words and a fuse store on the same clock.
//
// How it works
// - Core 2 on input B applies the input-B offset trim, not input A's.
// - Core 3 on input C applies bits 11:0 of its input-C offset register.
// - Core 3 on input D applies bits 11:0 of its input-D offset register.
// - Cores 4 and 5 apply one fixed offset trim whatever input they sample.
// - Every trim is loaded from fuse storage after reset, never left zero.
// - Cores 0 and 1 apply bits 4:0 of their own gain register.
// - Core 2 on input A applies the input-A fine gain trim.
// - Offset trim fields are unsigned quantities.
// - Core 2 on input B applies the input-B fine gain trim.
package ogt_pkg;

    // Slot count: eight offset registers then eight gain registers.
    localparam int unsigned NUM_SLOTS    = 16;
    localparam int unsigned SLOT_W       = 4;
    localparam int unsigned NUM_CORES    = 6;
    localparam int unsigned REG_W        = 16;
    localparam int unsigned OFS_W        = 12;
    localparam int unsigned GAIN_W       = 5;
    localparam int unsigned GAIN_REG_W   = 8;
    localparam int unsigned IDX_W        = 12;

    // Register indices; the byte address is four times the index.
    localparam logic [11:0] IDX_OFS_CORE0     = 12'h330;
    localparam logic [11:0] IDX_OFS_CORE1     = 12'h332;
    localparam logic [11:0] IDX_OFS_CORE2_A   = 12'h334;
    localparam logic [11:0] IDX_OFS_CORE2_B   = 12'h336;
    localparam logic [11:0] IDX_OFS_CORE3_C   = 12'h338;
    localparam logic [11:0] IDX_OFS_CORE3_D   = 12'h33A;
    localparam logic [11:0] IDX_OFS_CORE4     = 12'h33C;
    localparam logic [11:0] IDX_OFS_CORE5     = 12'h33E;
    localparam logic [11:0] IDX_GAIN_CORE0    = 12'h360;
    localparam logic [11:0] IDX_GAIN_CORE1    = 12'h361;
    localparam logic [11:0] IDX_GAIN_CORE2_A  = 12'h362;
    localparam logic [11:0] IDX_GAIN_CORE2_B  = 12'h363;
    localparam logic [11:0] IDX_GAIN_CORE3_C  = 12'h364;
    localparam logic [11:0] IDX_GAIN_CORE3_D  = 12'h365;
    localparam logic [11:0] IDX_GAIN_CORE4    = 12'h366;
    localparam logic [11:0] IDX_GAIN_CORE5    = 12'h367;
    localparam logic [11:0] IDX_STATUS        = 12'h370;

    // Offset registers sit on even indices, gain registers on consecutive.
    localparam logic [11:0] OFS_BASE_IDX  = 12'h330;
    localparam logic [11:0] OFS_LAST_IDX  = 12'h33E;
    localparam logic [11:0] GAIN_BASE_IDX = 12'h360;
    localparam logic [11:0] GAIN_LAST_IDX = 12'h367;
    localparam logic [SLOT_W-1:0] GAIN_SLOT0 = 4'h8;

    // Field layout.
    localparam int unsigned OFS_MSB     = 11;
    localparam int unsigned GAIN_MSB    = 4;
    localparam int unsigned STAT_LOADED = 0;
    localparam int unsigned STAT_BUSY   = 1;

    // Reset values of the registers before the fuse load replaces them.
    localparam logic [REG_W-1:0] OFS_RESET  = 16'h0000;
    localparam logic [REG_W-1:0] GAIN_RESET = 16'h0000;

    // Slot of the primary and alternate trims of each core.
    localparam logic [5:0][3:0] CORE_OFS_PRI  = {4'h7, 4'h6, 4'h4, 4'h2,
                                                 4'h1, 4'h0};
    localparam logic [5:0][3:0] CORE_OFS_ALT  = {4'h7, 4'h6, 4'h5, 4'h3,
                                                 4'h1, 4'h0};
    localparam logic [5:0][3:0] CORE_GAIN_PRI = {4'hF, 4'hE, 4'hC, 4'hA,
                                                 4'h9, 4'h8};
    localparam logic [5:0][3:0] CORE_GAIN_ALT = {4'hF, 4'hE, 4'hD, 4'hB,
                                                 4'h9, 4'h8};

    // Fuse load sequencer states.
    typedef enum logic [1:0] {
        OGT_LOAD_REQ,
        OGT_LOAD_WAIT,
        OGT_READY
    } ogt_load_state_t;

endpackage

// [logic/ogt_core_trim_sel.sv]
// One converter core's trim selector: picks the trims for the sampled input.
// Assumes both trim pairs and the input select come from the same clock.
`timescale 1ns/1ns
module ogt_core_trim_sel #(
    parameter int unsigned OFS_W  = 12,
    parameter int unsigned GAIN_W = 5
) (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Stored trims for the primary and the alternate input.
    input  wire logic [OFS_W-1:0]  ofs_pri,
    input  wire logic [OFS_W-1:0]  ofs_alt,
    input  wire logic [GAIN_W-1:0] gain_pri,
    input  wire logic [GAIN_W-1:0] gain_alt,
    // High while the core samples its alternate input.
    input  wire logic              sel_alt,
    // Trims applied to the core.
    output logic      [OFS_W-1:0]  ofs_applied,
    output logic      [GAIN_W-1:0] gain_applied
);

    initial begin
        if (OFS_W == 0 || GAIN_W == 0) begin
            $error("Trim widths must be nonzero.");
        end
    end

    // Registered so the core sees one clean change per select or write.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ofs_applied  <= '0;
            gain_applied <= '0;
        end else begin
            ofs_applied  <= sel_alt ? ofs_alt : ofs_pri;
            gain_applied <= sel_alt ? gain_alt : gain_pri;
        end
    end

endmodule

// [logic/ogt_trim_bank.sv]
// Offset and fine gain trim bank for six converter cores, APB register port.
// Assumes a fuse store that answers one read request at a time, and input
// selects for cores 2 and 3 driven by logic on the same clock.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
module ogt_trim_bank #(
    parameter int unsigned NUM_CORES = 6
) (
    // Clock and reset.
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    // APB slave.
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [13:0]              paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Fuse storage read port.
    output logic                          fuse_rd_req,
    output logic      [3:0]               fuse_rd_index,
    input  wire logic [15:0]              fuse_rd_data,
    input  wire logic                     fuse_rd_valid,
    // Calibration state shown to software.
    input  wire logic                     offset_cal_busy,
    // Input selects of the dual-input cores.
    input  wire logic                     core2_samples_input_b,
    input  wire logic                     core3_samples_input_d,
    // Trims applied to the cores.
    output logic      [NUM_CORES-1:0][11:0] core_offset_trim,
    output logic      [NUM_CORES-1:0][4:0]  core_gain_trim
);

    localparam int unsigned NSLOT = ogt_pkg::NUM_SLOTS;
    localparam int unsigned SW    = ogt_pkg::SLOT_W;

    initial begin
        if (NUM_CORES != ogt_pkg::NUM_CORES) begin
            $error("The slot map serves exactly six cores.");
        end
    end

    // Maps a register index onto a storage slot; valid is low if unmapped.
    function automatic logic [SW:0] slot_of(input logic [11:0] idx);
        logic [11:0] rel;
        rel = '0;
        if (idx >= ogt_pkg::OFS_BASE_IDX && idx <= ogt_pkg::OFS_LAST_IDX
            && !idx[0]) begin
            rel = idx - ogt_pkg::OFS_BASE_IDX;
            slot_of = {1'b1, rel[SW:1]};
        end else if (idx >= ogt_pkg::GAIN_BASE_IDX
                     && idx <= ogt_pkg::GAIN_LAST_IDX) begin
            rel = idx - ogt_pkg::GAIN_BASE_IDX;
            slot_of = {1'b1, ogt_pkg::GAIN_SLOT0 | rel[SW-1:0]};
        end else begin
            slot_of = '0;
        end
    endfunction

    // Width mask of a slot: offset slots hold 16 bits, gain slots 8.
    function automatic logic [15:0] slot_mask(input logic [SW-1:0] s);
        if (s[SW-1]) begin
            slot_mask = 16'h00FF;
        end else begin
            slot_mask = 16'hFFFF;
        end
    endfunction

    // Storage of all trims, addressed by slot.
    logic [15:0]             trim_q [NSLOT];
    ogt_pkg::ogt_load_state_t load_state_q;
    logic [SW-1:0]           load_cnt_q;
    logic                    loaded;
    logic                    ready_q;

    // APB decode of the current transfer.
    logic [11:0]   reg_idx;
    logic [SW:0]   dec;
    logic          dec_hit;
    logic          dec_status;
    logic [SW-1:0] dec_slot;
    logic          access;
    logic          wr_fire;
    logic [15:0]   wr_bytes;

    assign reg_idx    = paddr[13:2];
    assign dec        = slot_of(reg_idx);
    assign dec_hit    = dec[SW];
    assign dec_slot   = dec[SW-1:0];
    assign dec_status = (reg_idx == ogt_pkg::IDX_STATUS);
    assign access     = psel && penable && pready;
    // Writes only land once the fuse values are in, so software never loses
    // a value to the loader overwriting it afterwards.
    assign wr_fire    = access && pwrite && dec_hit && !pslverr;
    assign wr_bytes   = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Accesses stall until one cycle after the fuse load ends, so a stalled
    // read captures its word once every trim is in; then zero wait states.
    assign pready  = ready_q;
    assign pslverr = psel && penable && !(dec_hit || (dec_status && !pwrite));
    assign loaded  = (load_state_q == ogt_pkg::OGT_READY);

    // Ready lags the load by a cycle so the read flop sees loaded trims.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= loaded;
        end
    end

    // Fuse load sequencer: one request per slot, held until answered.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_state_q <= ogt_pkg::OGT_LOAD_REQ;
            load_cnt_q   <= '0;
        end else begin
            case (load_state_q)
                ogt_pkg::OGT_LOAD_REQ: begin
                    load_state_q <= ogt_pkg::OGT_LOAD_WAIT;
                end
                ogt_pkg::OGT_LOAD_WAIT: begin
                    if (fuse_rd_valid) begin
                        load_cnt_q <= load_cnt_q + 1'b1;
                        if (load_cnt_q == SW'(NSLOT - 1)) begin
                            load_state_q <= ogt_pkg::OGT_READY;
                        end else begin
                            load_state_q <= ogt_pkg::OGT_LOAD_REQ;
                        end
                    end
                end
                ogt_pkg::OGT_READY: begin
                    load_state_q <= ogt_pkg::OGT_READY;
                end
                default: begin
                    load_state_q <= ogt_pkg::OGT_LOAD_REQ;
                end
            endcase
        end
    end

    // Fuse request outputs come straight from the sequencer flip-flops.
    assign fuse_rd_req   = (load_state_q == ogt_pkg::OGT_LOAD_WAIT);
    assign fuse_rd_index = load_cnt_q;

    // Trim storage: fuse load first, then byte-enabled software writes.
    // Reserved bits are stored as written; keeping them zero is software's
    // duty.
    generate
        for (genvar s = 0; s < NSLOT; s++) begin : g_slot
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    trim_q[s] <= (s >= 8) ? ogt_pkg::GAIN_RESET
                                          : ogt_pkg::OFS_RESET;
                end else if (fuse_rd_req && fuse_rd_valid
                             && load_cnt_q == SW'(s)) begin
                    trim_q[s] <= fuse_rd_data & slot_mask(SW'(s));
                end else if (wr_fire && dec_slot == SW'(s)) begin
                    // Only the addressed slot changes.
                    trim_q[s] <= ((trim_q[s] & ~wr_bytes)
                                 | (pwdata[15:0] & wr_bytes))
                                 & slot_mask(SW'(s));
                end
            end
        end
    endgenerate

    // Word addressed by the current transfer, before it is registered.
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        if (dec_hit) begin
            rd_word = {16'h0000, trim_q[dec_slot]};
        end else if (dec_status) begin
            rd_word[ogt_pkg::STAT_LOADED] = loaded;
            rd_word[ogt_pkg::STAT_BUSY]   = offset_cal_busy;
        end
    end

    // Read data is captured in the setup cycle so it stands in a flip-flop
    // during the access phase; zero-wait reads then see a stable word.
    logic [31:0] prdata_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_word;
        end else if (psel && penable && !pwrite && !pready) begin
            // Keep tracking while the fuse load stalls the transfer.
            prdata_q <= rd_word;
        end
    end
    assign prdata = prdata_q;

    // Input selects passed to the per-core selectors.
    logic [NUM_CORES-1:0] sel_alt;
    always_comb begin
        sel_alt    = '0;
        sel_alt[2] = core2_samples_input_b;
        sel_alt[3] = core3_samples_input_d;
    end

    // One selector per core; cores 0, 1, 4 and 5 map both inputs to the
    // same slot, so their trims never depend on the sampled input.
    generate
        for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
            logic [15:0] ofs_p;
            logic [15:0] ofs_a;
            logic [15:0] gain_p;
            logic [15:0] gain_a;
            assign ofs_p  = trim_q[ogt_pkg::CORE_OFS_PRI[c]];
            assign ofs_a  = trim_q[ogt_pkg::CORE_OFS_ALT[c]];
            assign gain_p = trim_q[ogt_pkg::CORE_GAIN_PRI[c]];
            assign gain_a = trim_q[ogt_pkg::CORE_GAIN_ALT[c]];
            ogt_core_trim_sel #(
                .OFS_W  (ogt_pkg::OFS_W),
                .GAIN_W (ogt_pkg::GAIN_W)
            ) u_sel (
                .core_clk     (core_clk),
                .rst_n        (rst_n),
                .ofs_pri      (ofs_p[ogt_pkg::OFS_MSB:0]),
                .ofs_alt      (ofs_a[ogt_pkg::OFS_MSB:0]),
                .gain_pri     (gain_p[ogt_pkg::GAIN_MSB:0]),
                .gain_alt     (gain_a[ogt_pkg::GAIN_MSB:0]),
                .sel_alt      (sel_alt[c]),
                .ofs_applied  (core_offset_trim[c]),
                .gain_applied (core_gain_trim[c])
            );
        end
    endgenerate

endmodule

// [sim/ogt_trim_bank_checker.sv]
// Checker for the trim bank ports: bus answers, fuse load and trims.
// Assumes it is bound to the bank with the port names used below.
`timescale 1ns/1ns
module ogt_trim_bank_checker #(
    parameter int unsigned NUM_CORES = 6
) (
    // Clock and reset.
    input wire logic                       core_clk,
    input wire logic                       rst_n,
    // APB side.
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [13:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    // Fuse side.
    input wire logic                       fuse_rd_req,
    input wire logic [3:0]                 fuse_rd_index,
    input wire logic                       fuse_rd_valid,
    // Applied trims.
    input wire logic [NUM_CORES-1:0][11:0] core_offset_trim,
    input wire logic [NUM_CORES-1:0][4:0]  core_gain_trim
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Completed bus writes and fuse words, shared by several checks.
    logic wr_done;
    logic fuse_take;
    assign wr_done   = psel && penable && pready && pwrite;
    assign fuse_take = fuse_rd_req && fuse_rd_valid;

    chk_ready_low: assert property (
        $rose(rst_n) |-> !pready [*8])
        else $error("bus answered before the fuse load ended");
    chk_fuse_hold: assert property (
        fuse_rd_req && !fuse_rd_valid |=> fuse_rd_req
        && $stable(fuse_rd_index))
        else $error("fuse request dropped or moved before its answer");
    chk_fuse_gap: assert property (
        fuse_take |=> !fuse_rd_req)
        else $error("fuse request not idle after a taken word");
    chk_fuse_ascend: assert property (
        fuse_take && fuse_rd_index != 4'hF |=> ##1 fuse_rd_req
        && fuse_rd_index == $past(fuse_rd_index, 2) + 4'h1)
        else $error("fuse slots not requested in ascending order");
    chk_core5_write: assert property (
        wr_done && paddr == 14'h0CF8 |=> ##1
        core_offset_trim[5] == $past(pwdata[11:0], 2))
        else $error("core 5 offset does not follow its register");
    chk_fine_gain_trim_core_zero_write: assert property (
        wr_done && paddr == 14'h0D80 |=> ##1
        core_gain_trim[0] == $past(pwdata[4:0], 2))
        else $error("core 0 gain does not follow its register");
    chk_core0_alone: assert property (
        wr_done && paddr == 14'h0CC0 |=> ##1
        $stable(core_offset_trim[5]) && $stable(core_gain_trim))
        else $error("core 0 offset write disturbed other trims");
    chk_unmapped_kept: assert property (
        psel && penable && pready && paddr == 14'h0D00 |-> pslverr
        ##1 $stable(core_offset_trim) ##1 $stable(core_offset_trim))
        else $error("unmapped access not refused or changed trims");
endmodule

bind ogt_trim_bank ogt_trim_bank_checker #(.NUM_CORES(NUM_CORES))
    i_ogt_trim_bank_checker (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .fuse_rd_req, .fuse_rd_index, .fuse_rd_valid,
    .core_offset_trim, .core_gain_trim
);

// [sim/ogt_trim_bank_tb_top.sv]
// Bench for the trim bank: APB tasks, a fuse store stand-in, selects.
// Assumes the checker file is compiled ahead of this one.
`timescale 1ns/1ns
module ogt_trim_bank_tb_top;
    // Design ports.
    logic             core_clk;
    logic             rst_n;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [13:0]      paddr;
    logic [31:0]      pwdata;
    logic [3:0]       pstrb;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             fuse_rd_req;
    logic [3:0]       fuse_rd_index;
    logic [15:0]      fuse_rd_data;
    logic             fuse_rd_valid;
    logic             offset_cal_busy;
    logic             core2_samples_input_b;
    logic             core3_samples_input_d;
    logic [5:0][11:0] core_offset_trim;
    logic [5:0][4:0]  core_gain_trim;
    // Bench state.
    int               fail_count;
    int               comparisons;
    logic [15:0]      exp_q [16];
    logic [31:0]      rd;
    logic             err;
    logic [3:0]       ws [5] = '{4'h5, 4'h7, 4'h0, 4'h8, 4'hB};
    logic [15:0]      wv [5] = '{16'h0ABC, 16'h0FFF, 16'h0001, 16'h001F,
                                 16'h0015};

    ogt_trim_bank i_ogt_trim_bank (
        .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .fuse_rd_req, .fuse_rd_index,
        .fuse_rd_data, .fuse_rd_valid, .offset_cal_busy,
        .core2_samples_input_b, .core3_samples_input_d,
        .core_offset_trim, .core_gain_trim
    );

    // Fuse word of each slot; the top nibble is set to see it kept in offset slots and dropped in gain slots.
    function automatic logic [15:0] fuse_word(input logic [3:0] s);
        return 16'hCA50 + {12'h000, s} * 16'h0103;
    endfunction
    // Byte address of a slot: offsets on even indices, gains packed.
    function automatic logic [13:0] slot_addr(input logic [3:0] s);
        return s[3] ? {12'h360 + {9'h000, s[2:0]}, 2'b00}
                    : {12'h330 + {8'h00, s[2:0], 1'b0}, 2'b00};
    endfunction

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Fuse stand-in answers a cycle after each request; idle data toggles
    // so that a stale word can never pass for a fresh one.
    always @(posedge core_clk) begin
        fuse_rd_valid <= fuse_rd_req;
        fuse_rd_data  <= fuse_rd_req ? fuse_word(fuse_rd_index)
                                     : ~fuse_rd_data;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] expv);
        comparisons++;
        if (seen !== expv) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, expv, seen);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [13:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check_regs();
        for (int s = 0; s < 16; s++) begin
            apb(1'b0, slot_addr(s[3:0]), 32'h0);
            check("register", rd, {16'h0000, exp_q[s]});
        end
    endtask
    // Slots applied to each core under the present input selects.
    task automatic check_cores();
        logic [3:0]  os [6];
        logic [11:0] o;
        logic [4:0]  g;
        os = '{4'h0, 4'h1, core2_samples_input_b ? 4'h3 : 4'h2,
               core3_samples_input_d ? 4'h5 : 4'h4, 4'h6, 4'h7};
        for (int c = 0; c < 6; c++) begin
            o = exp_q[os[c]][11:0];
            g = exp_q[os[c] + 4'h8][4:0];
            check("ofs", core_offset_trim[c], o);
            check("gain", core_gain_trim[c], g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A hang anywhere ends the run as a failure.
    initial begin
        #50000;
        fail_count++;
        $display("[ERR] watchdog expected finish seen timeout");
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        fuse_rd_data = 16'h0000;
        fuse_rd_valid = 1'b0;
        offset_cal_busy = 1'b0;
        core2_samples_input_b = 1'b0;
        core3_samples_input_d = 1'b0;
        for (int s = 0; s < 16; s++) begin
            exp_q[s] = fuse_word(s[3:0]) & (s < 8 ? 16'hFFFF : 16'h00FF);
        end
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        // The first access stalls until every trim is loaded.
        apb(1'b0, 14'h0DC0, 32'h0);
        check("status", rd, 32'h1);
        check_regs();
        $display("test fuse load done");
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk);
            core2_samples_input_b <= m[0];
            core3_samples_input_d <= m[1];
            repeat (2) @(posedge core_clk);
            check_cores();
        end
        $display("test input selects done");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, slot_addr(ws[i]), {16'h0000, wv[i]});
            check("write error", err, 32'h0);
            exp_q[ws[i]] = wv[i];
        end
        check_regs();
        check_cores();
        $display("test single writes done");
        offset_cal_busy <= 1'b1;
        apb(1'b1, 14'h0D00, 32'h0000_0123);
        check("unmapped error", err, 32'h1);
        apb(1'b1, 14'h0DC0, 32'h0);
        check("status write error", err, 32'h1);
        apb(1'b0, 14'h0DC0, 32'h0);
        check("busy status", rd, 32'h3);
        offset_cal_busy <= 1'b0;
        check_regs();
        check_cores();
        $display("test refused accesses done");
        end_of_test();
    end
endmodule
